// ### verilog/pc_stack_pkg.sv
// package of constants and carrier types for the instruction sequencer
// assumes a 32-bit apb slave with a byte address and one word per register
package pc_stack_pkg;

    localparam int unsigned PC_W      = 13;  // hardware counter bits 12..0
    localparam int unsigned ADDR_W    = 14;  // bank bit above the counter
    localparam int unsigned STACK_N   = 8;   // return stack depth
    localparam int unsigned PADDR_W   = 8;   // apb byte address width

    // apb byte offsets, one aligned word each
    localparam logic [7:0] OFS_PC_LOW    = 8'h00;
    localparam logic [7:0] OFS_RB_LOW    = 8'h04;
    localparam logic [7:0] OFS_RB_HIGH   = 8'h08;
    localparam logic [7:0] OFS_STACK_IDX = 8'h0C;
    localparam logic [7:0] OFS_BANK      = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
    localparam logic [7:0] OFS_ALU_STAT  = 8'h1C;

    // field positions
    localparam int unsigned OSF_BIT      = 7;   // overflow flag in index reg
    localparam int unsigned EV_OVERFLOW  = 0;   // event bits in irq status
    localparam int unsigned EV_HELD_OFF  = 1;
    localparam int unsigned EV_PCL_JUMP  = 2;
    localparam int unsigned EV_W         = 3;

    // values after reset, plus the full depth and the interrupt vector
    localparam logic [12:0] PC_RESET     = 13'h0000;
    localparam logic [2:0]  IDX_RESET    = 3'h0;
    localparam logic [3:0]  DEPTH_RESET  = 4'h0;
    localparam logic [3:0]  DEPTH_FULL   = 4'h8;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;  // plain default entry

    // the four instruction phases
    typedef enum logic [1:0] { PH_T1, PH_T2, PH_T3, PH_T4 } phase_t;

    // sequencing command presented by decode during phase four
    typedef enum logic [2:0] {
        CMD_SEQ, CMD_JUMP, CMD_CALL, CMD_RET, CMD_INTERRUPT_RETURN_OP, CMD_SKIP_Z, CMD_SKIP_NZ
    } cmd_t;

    // alu operations
    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
        ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC
    } alu_op_t;

    // condition flags written back after each operation
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } alu_flags_t;

    // one decoded instruction from the decode side
    typedef struct packed {
        cmd_t        cmd;
        logic [12:0] target;
        alu_op_t     op;
        logic [7:0]  opa;
        logic [7:0]  opb;
    } dec_req_t;

endpackage // pc_stack_pkg

// ### verilog/pc_stack_sequencer.sv
// instruction sequencer: phases, program counter, return stack, alu
// assumes decode presents one request per instruction cycle, held through
// phase four, and an apb master on the same clock
//
// Operation
// [RL1] four phases form one instruction cycle
// [RL2] counter steps into phase one, fetch follows
// [RL3] branches cost one extra dummy cycle
// [RL4] bank select bit sits above counter bits
// [RL5] low byte write jumps in page, dummy
// [RL6] taken skip replaces next instruction with dummy
// [RL7] low readback copies high byte to buffer
// [RL8] software reads low before high readback
// [RL9] eight-level stack, no software access to entries
// [RL10] call and acknowledge push, returns pop
// [RL11] reset leaves the stack empty
// [RL12] full stack holds interrupt until return
// [RL13] call on full stack still executes
// [RL14] overflow flag sticky, cleared by software
// [RL15] index counts up modulo eight per call
// [RL16] empty returns count index down, flag set
// [RL17] alu result and status written back
// [RL18] alu arithmetic, logic, rotate, branch tests
// [RL19] stack is a circular eight-entry buffer
//
// The address map and the APB slave port were decided locally.
module pc_stack_sequencer (
    input  wire logic                    clock,
    input  wire logic                    reset,
    // apb slave
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // decode side
    input  wire pc_stack_pkg::dec_req_t  dec_req,
    input  wire logic                    irq_req,
    output logic      [13:0]             fetch_addr,
    output logic                         fetch_strobe,
    output logic                         dummy_cycle,
    output logic      [1:0]              phase,
    output logic                         irq_ack,
    output logic      [7:0]              alu_result,
    output pc_stack_pkg::alu_flags_t     alu_flags,
    output logic                         irq
);

    // alu: returns {flags, result}
    function automatic logic [11:0] alu_calc(
        input pc_stack_pkg::alu_op_t op,
        input logic [7:0]            a,
        input logic [7:0]            b,
        input logic                  cin
    );
        logic [8:0] s;
        logic [4:0] h;
        logic       ov;
        s  = 9'h000;
        h  = 5'h00;
        ov = 1'b0;
        case (op)
            pc_stack_pkg::ALU_ADD: begin
                s  = {1'b0, a} + {1'b0, b};
                h  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                ov = (a[7] == b[7]) && (s[7] != a[7]);
            end
            pc_stack_pkg::ALU_ADC: begin
                s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                ov = (a[7] == b[7]) && (s[7] != a[7]);
            end
            pc_stack_pkg::ALU_SUB: begin
                // carry set means no borrow
                s  = {1'b0, a} + {1'b0, ~b} + 9'h001;
                h  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
                ov = (a[7] != b[7]) && (s[7] != a[7]);
            end
            pc_stack_pkg::ALU_SBC: begin
                s  = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
                h  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
                ov = (a[7] != b[7]) && (s[7] != a[7]);
            end
            pc_stack_pkg::ALU_DAA: begin
                // adjust each nibble above nine
                s = {1'b0, a};
                if (a[3:0] > 4'h9) begin
                    s = s + 9'h006;
                end
                if (s[7:4] > 4'h9 || cin) begin
                    s = s + 9'h060;
                end
                h = {1'b0, s[3:0]};
            end
            pc_stack_pkg::ALU_AND: s = {1'b0, a & b};
            pc_stack_pkg::ALU_OR:  s = {1'b0, a | b};
            pc_stack_pkg::ALU_XOR: s = {1'b0, a ^ b};
            pc_stack_pkg::ALU_CPL: s = {1'b0, ~a};
            pc_stack_pkg::ALU_RR:  s = {1'b0, a[0], a[7:1]};
            pc_stack_pkg::ALU_RRC: s = {a[0], cin, a[7:1]};
            pc_stack_pkg::ALU_RL:  s = {1'b0, a[6:0], a[7]};
            pc_stack_pkg::ALU_RLC: s = {a[7], a[6:0], cin};
            pc_stack_pkg::ALU_INC: s = {1'b0, a + 8'h01};
            pc_stack_pkg::ALU_DEC: s = {1'b0, a - 8'h01};
            default:               s = {1'b0, a};
        endcase
        alu_calc = {ov, (s[7:0] == 8'h00), h[4], s[8], s[7:0]};
    endfunction

    // event field width, needed before the registers below
    localparam int unsigned EV_W_L = pc_stack_pkg::EV_W;

    // registers
    pc_stack_pkg::phase_t    phase_q;         // current phase
    logic [12:0]             pc_q;            // hardware counter bits
    logic                    bank_q;          // code_bank_select_bit
    logic [13:0]             exec_q;          // address now executing
    logic                    dummy_q;         // this cycle is a dummy
    logic [12:0]             stack_q [8];     // return stack entries
    logic [2:0]              idx_q;           // stack index
    logic [3:0]              depth_q;         // entries held, 0..8
    logic                    osf_q;           // stack_overflow_flag
    logic                    pcl_pend_q;      // low byte write waiting
    logic [7:0]              pcl_val_q;       // value written to low byte
    logic                    irq_pend_q;      // interrupt request recorded
    logic [7:0]              rb_high_q;       // readback high buffer
    logic [EV_W_L-1:0]       ev_q;            // sticky event bits
    logic [EV_W_L-1:0]       mask_q;          // event mask
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic [13:0]             fetch_q;
    logic                    fetch_stb_q;
    logic                    ack_q;
    logic [7:0]              alu_res_q;
    pc_stack_pkg::alu_flags_t flags_q;
    logic                    irq_q;

    // apb decode; one wait cycle so read data comes from a flop
    wire       acc      = psel && penable;
    wire       done     = acc && pready_q;
    wire       wr_done  = done && pwrite;
    wire       rd_done  = done && !pwrite;
    wire       sel_pcl  = (paddr == pc_stack_pkg::OFS_PC_LOW);
    wire       sel_rbl  = (paddr == pc_stack_pkg::OFS_RB_LOW);
    wire       sel_rbh  = (paddr == pc_stack_pkg::OFS_RB_HIGH);
    wire       sel_idx  = (paddr == pc_stack_pkg::OFS_STACK_IDX);
    wire       sel_bank = (paddr == pc_stack_pkg::OFS_BANK);
    wire       sel_ist  = (paddr == pc_stack_pkg::OFS_IRQ_STAT);
    wire       sel_imsk = (paddr == pc_stack_pkg::OFS_IRQ_MASK);
    wire       sel_alu  = (paddr == pc_stack_pkg::OFS_ALU_STAT);
    wire       mapped   = sel_pcl || sel_rbl || sel_rbh || sel_idx ||
                          sel_bank || sel_ist || sel_imsk || sel_alu;

    // read mux; the stack entries themselves have no address
    logic [31:0] rd_mux;
    always_comb begin // see [RL9]
        rd_mux = 32'h0000_0000;
        if (sel_pcl) begin
            rd_mux = {24'h00_0000, pc_q[7:0]};
        end else if (sel_rbl) begin
            rd_mux = {24'h00_0000, exec_q[7:0]};           // see [RL7]
        end else if (sel_rbh) begin
            rd_mux = {24'h00_0000, rb_high_q};             // see [RL7]
        end else if (sel_idx) begin
            rd_mux = {24'h00_0000, osf_q, 4'h0, idx_q};
        end else if (sel_bank) begin
            rd_mux = {31'h0000_0000, bank_q};
        end else if (sel_ist) begin
            rd_mux = {29'h0000_0000, ev_q};
        end else if (sel_imsk) begin
            rd_mux = {29'h0000_0000, mask_q};
        end else if (sel_alu) begin
            rd_mux = {28'h000_0000, flags_q};
        end
    end

    // sequencing decisions, all taken at the end of phase four
    wire         t4       = (phase_q == pc_stack_pkg::PH_T4);
    wire         full     = (depth_q == pc_stack_pkg::DEPTH_FULL);
    wire         empty    = (depth_q == pc_stack_pkg::DEPTH_RESET);
    wire [11:0]  alu_out  = alu_calc(dec_req.op, dec_req.opa, dec_req.opb,
                                     flags_q.c);
    wire         live     = t4 && !dummy_q;
    wire         is_seq   = (dec_req.cmd == pc_stack_pkg::CMD_SEQ);
    wire         do_pcl   = live && pcl_pend_q;
    wire         do_ack   = live && !pcl_pend_q && irq_pend_q && is_seq &&
                            !full;                                 // see [RL12]
    wire         held_off = live && irq_pend_q && full;            // see [RL12]
    wire         go       = live && !pcl_pend_q && !do_ack;
    wire         do_jump  = go && (dec_req.cmd == pc_stack_pkg::CMD_JUMP);
    wire         do_call  = go && (dec_req.cmd == pc_stack_pkg::CMD_CALL);
    wire         do_ret   = go && (dec_req.cmd == pc_stack_pkg::CMD_RET ||
                                   dec_req.cmd == pc_stack_pkg::CMD_INTERRUPT_RETURN_OP);
    wire         do_skip  = go && ((dec_req.cmd == pc_stack_pkg::CMD_SKIP_Z &&
                                    alu_out[10]) ||
                                   (dec_req.cmd == pc_stack_pkg::CMD_SKIP_NZ &&
                                    !alu_out[10]));                // see [RL18]
    wire         push     = do_call || do_ack;                     // see [RL10]
    wire         ovf_ev   = (do_call && full) || (do_ret && empty);
    wire [2:0]   idx_dn   = idx_q - 3'h1;
    wire         branch   = do_pcl || do_ack || do_jump || do_call ||
                            do_ret || do_skip;

    // next counter value
    logic [12:0] pc_d;
    always_comb begin
        pc_d = pc_q + 13'h0001;                                    // see [RL2]
        if (do_pcl) begin
            pc_d = {pc_q[12:8], pcl_val_q};                        // see [RL5]
        end else if (do_ack) begin
            pc_d = pc_stack_pkg::IRQ_VECTOR;
        end else if (do_jump || do_call) begin
            pc_d = dec_req.target;
        end else if (do_ret) begin
            pc_d = stack_q[idx_dn];                                // see [RL10]
        end
    end

    // event bits for the interrupt output
    wire [EV_W_L-1:0] ev_set = {do_pcl, held_off, ovf_ev};

    // phase counter, counter, fetch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_q     <= pc_stack_pkg::PH_T1;
            pc_q        <= pc_stack_pkg::PC_RESET;
            exec_q      <= 14'h0000;
            dummy_q     <= 1'b0;
            fetch_q     <= 14'h0000;
            fetch_stb_q <= 1'b0;
        end else begin
            phase_q     <= pc_stack_pkg::phase_t'(phase_q + 2'h1); // see [RL1]
            fetch_stb_q <= t4;                                     // see [RL2]
            if (t4) begin
                pc_q    <= pc_d;                                   // see [RL2]
                // fetch the new counter, so a dummy cycle fetches the
                // branch target and a push saves the next address
                fetch_q <= {bank_q, pc_d};                         // see [RL4]
                exec_q  <= fetch_q;
                dummy_q <= branch;                    // see [RL3] see [RL6]
            end
        end
    end

    // return stack, circular over the index
    always_ff @(posedge clock) begin
        if (push) begin
            stack_q[idx_q] <= pc_q;                    // see [RL13] see [RL19]
        end
    end

    // stack index, depth, overflow flag
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            idx_q   <= pc_stack_pkg::IDX_RESET;                    // see [RL11]
            depth_q <= pc_stack_pkg::DEPTH_RESET;
            osf_q   <= 1'b0;
        end else begin
            if (push) begin
                idx_q <= idx_q + 3'h1;                             // see [RL15]
                if (!full) begin
                    depth_q <= depth_q + 4'h1;
                end
            end else if (do_ret) begin
                idx_q <= idx_dn;                                   // see [RL16]
                if (!empty) begin
                    depth_q <= depth_q - 4'h1;
                end
            end
            // hardware set wins over a software write
            if (ovf_ev) begin
                osf_q <= 1'b1;                                     // see [RL14]
            end else if (wr_done && sel_idx) begin
                osf_q <= pwdata[pc_stack_pkg::OSF_BIT];
            end
        end
    end

    // software side state and interrupt request tracking
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bank_q     <= 1'b0;
            pcl_pend_q <= 1'b0;
            pcl_val_q  <= 8'h00;
            irq_pend_q <= 1'b0;
            rb_high_q  <= 8'h00;
            mask_q     <= '0;
            ack_q      <= 1'b0;
        end else begin
            ack_q <= do_ack;
            if (wr_done && sel_bank) begin
                bank_q <= pwdata[0];                               // see [RL4]
            end
            if (wr_done && sel_pcl) begin
                pcl_pend_q <= 1'b1;                                // see [RL5]
                pcl_val_q  <= pwdata[7:0];
            end else if (do_pcl) begin
                pcl_pend_q <= 1'b0;
            end
            // a new request wins over the acknowledge clear
            if (irq_req) begin
                irq_pend_q <= 1'b1;                                // see [RL12]
            end else if (do_ack) begin
                irq_pend_q <= 1'b0;
            end
            if (rd_done && sel_rbl) begin
                rb_high_q <= {2'b00, exec_q[13:8]};        // see [RL7] see [RL8]
            end
            if (wr_done && sel_imsk) begin
                mask_q <= pwdata[EV_W_L-1:0];
            end
        end
    end

    // sticky events, cleared by a read; a new event survives the read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ev_q  <= '0;
            irq_q <= 1'b0;
        end else begin
            ev_q  <= ((rd_done && sel_ist) ? '0 : ev_q) | ev_set;
            irq_q <= |(ev_q & mask_q);
        end
    end

    // alu write-back at phase four of an executed instruction
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            alu_res_q <= 8'h00;
            flags_q   <= '0;
        end else if (live) begin
            alu_res_q <= alu_out[7:0];                             // see [RL17]
            flags_q   <= alu_out[11:8];                            // see [RL17]
        end
    end

    // apb answer: ready one cycle into the access phase
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else begin
            pready_q <= acc && !pready_q;
            prdata_q <= rd_mux;
            pslverr  <= acc && !pready_q && !mapped;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign fetch_addr   = fetch_q;
    assign fetch_strobe = fetch_stb_q;
    assign dummy_cycle  = dummy_q;
    assign phase        = phase_q;
    assign irq_ack      = ack_q;
    assign alu_result   = alu_res_q;
    assign alu_flags    = flags_q;
    assign irq          = irq_q;

    // phase four is followed by phase one
    property p_phase_step;
        @(posedge clock) disable iff (reset)
        phase_q == pc_stack_pkg::PH_T4 |=> phase_q == pc_stack_pkg::PH_T1;
    endproperty
    a_phase_step: assert property (p_phase_step) // see [RL1]
        else $error("phase did not wrap to one");

    // sequential step of the counter
    property p_pc_step;
        @(posedge clock) disable iff (reset)
        t4 && !branch |=> pc_q == $past(pc_q) + 13'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) // see [RL2]
        else $error("counter did not step by one");

    // a branch is followed by a full dummy cycle
    sequence s_dummy_cycle;
        dummy_q [*4];
    endsequence
    property p_branch_dummy;
        @(posedge clock) disable iff (reset)
        t4 && branch |=> s_dummy_cycle ##1 !dummy_q;
    endproperty
    a_branch_dummy: assert property (p_branch_dummy) // see [RL3]
        else $error("branch lacked one dummy cycle");

    // low byte write stays inside the page
    property p_pcl_page;
        @(posedge clock) disable iff (reset)
        do_pcl |=> pc_q[12:8] == $past(pc_q[12:8]) && dummy_q;
    endproperty
    a_pcl_page: assert property (p_pcl_page) // see [RL5]
        else $error("low byte jump left the page");

    // full stack withholds acknowledge
    property p_no_ack_full;
        @(posedge clock) disable iff (reset)
        full |-> !do_ack;
    endproperty
    a_no_ack_full: assert property (p_no_ack_full) // see [RL12]
        else $error("acknowledge given with a full stack");

    // flag is not cleared by hardware
    property p_osf_sticky;
        @(posedge clock) disable iff (reset)
        osf_q && !(wr_done && sel_idx) |=> osf_q;
    endproperty
    a_osf_sticky: assert property (p_osf_sticky) // see [RL14]
        else $error("overflow flag dropped without a write");

    // overflowing call sets the flag and still wraps the index
    property p_call_full;
        @(posedge clock) disable iff (reset)
        push && full |=> osf_q && idx_q == $past(idx_q) + 3'h1 && full;
    endproperty
    a_call_full: assert property (p_call_full) // see [RL15]
        else $error("overflowing call handled wrongly");

    // return from empty wraps the index downward
    property p_ret_empty;
        @(posedge clock) disable iff (reset)
        do_ret && empty |=> osf_q && idx_q == $past(idx_q) - 3'h1 && empty;
    endproperty
    a_ret_empty: assert property (p_ret_empty) // see [RL16]
        else $error("empty return handled wrongly");

    // readback buffer follows the low read
    property p_rb_copy;
        @(posedge clock) disable iff (reset)
        rd_done && sel_rbl |=> rb_high_q == {2'b00, $past(exec_q[13:8])};
    endproperty
    a_rb_copy: assert property (p_rb_copy) // see [RL7]
        else $error("readback buffer not loaded");

endmodule // pc_stack_sequencer

// ### verification/decode_model.sv
// decode side model: hands queued requests to the sequencer
// assumes phase and dummy_cycle come from the sequencer, same clock
module decode_model (
    input  wire logic              clock,
    input  wire logic [1:0]        phase,
    input  wire logic              dummy_cycle,
    output pc_stack_pkg::dec_req_t dec_req
);
    timeunit 1ns;
    timeprecision 1ps;
    pc_stack_pkg::dec_req_t q[$];  // requests waiting for a slot
    initial dec_req = '0;
    // present in T3 so it is held across the T4 edge, else plain step
    always @(posedge clock) begin
        if (phase == 2'h2 && !dummy_cycle && q.size() > 0) begin
            dec_req <= q.pop_front();
        end else if (phase == 2'h0) begin
            dec_req <= '0;
        end
    end
endmodule // decode_model

// ### verification/test_pc_stack_sequencer.sv
// bench for the sequencer: apb master, decode model, scenario tasks
// assumes one 250 MHz clock shared by all parts
module test_pc_stack_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset, psel, penable, pwrite, irq_req, err;
    logic        pready, pslverr, fetch_strobe, dummy_cycle, irq_ack, irq;
    logic [7:0]  paddr, alu_result;
    logic [31:0] pwdata, prdata, r;
    logic [13:0] fetch_addr;
    logic [1:0]  phase;
    pc_stack_pkg::alu_flags_t alu_flags;
    pc_stack_pkg::dec_req_t   dec_req;
    int          bad_count = 0, n_compared = 0, n;
    always #2 clock = ~clock;  // 4 ns period
    pc_stack_sequencer dut (.clock(clock), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dec_req(dec_req), .irq_req(irq_req), .fetch_addr(fetch_addr),
        .fetch_strobe(fetch_strobe), .dummy_cycle(dummy_cycle),
        .phase(phase), .irq_ack(irq_ack), .alu_result(alu_result),
        .alu_flags(alu_flags), .irq(irq));
    decode_model m (.clock(clock), .phase(phase),
        .dummy_cycle(dummy_cycle), .dec_req(dec_req));
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic hang;  // a bound ran out
        bad_count++;
        tally_and_finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // one apb transfer; read data and error land in r and err
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
            if (k > 20) hang;
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input logic v);  // bounded wait on dummy level
        int k;
        k = 0;
        while (dummy_cycle !== v) begin
            @(posedge clock);
            k++;
            if (k > 60) hang;
        end
    endtask
    // one branching request, returns once its dummy cycle starts
    task automatic run(input pc_stack_pkg::cmd_t c, input logic [12:0] t);
        pc_stack_pkg::dec_req_t q;
        q = '0;
        q.cmd = c;
        q.target = t;
        q.op = pc_stack_pkg::ALU_SUB;
        q.opa = 8'h05;
        q.opb = 8'h05;
        wt(1'b0);
        m.q.push_back(q);
        wt(1'b1);
    endtask
    task automatic do_reset;
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
    endtask
    task automatic t_calls;  // nine calls, flag, event, clear
        apb(1'b1, pc_stack_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        apb(1'b0, pc_stack_pkg::OFS_STACK_IDX, 32'h0000_0000);
        chk("index after reset", 32'h0000_0000, r);
        for (int i = 1; i <= 9; i++) begin
            run(pc_stack_pkg::CMD_CALL, 13'h0100);
            apb(1'b0, pc_stack_pkg::OFS_STACK_IDX, 32'h0000_0000);
            chk("index on call", 32'({i == 9, 4'h0, 3'(i)}), r);
        end
        chk("irq line", 32'h0000_0001, 32'(irq));
        apb(1'b0, pc_stack_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        chk("overflow event", 32'h0000_0001, r & 32'h0000_0001);
        apb(1'b0, pc_stack_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        chk("irq after clear", 32'h0000_0000, 32'(irq));
        apb(1'b1, pc_stack_pkg::OFS_STACK_IDX, 32'h0000_0000);
        apb(1'b0, pc_stack_pkg::OFS_STACK_IDX, 32'h0000_0000);
        chk("flag cleared", 32'h0000_0001, r);
    endtask
    task automatic t_rets;  // returns from an empty stack
        do_reset;
        for (int i = 1; i <= 8; i++) begin
            run(pc_stack_pkg::CMD_RET, 13'h0000);
            apb(1'b0, pc_stack_pkg::OFS_STACK_IDX, 32'h0000_0000);
            chk("index on ret", 32'({1'b1, 4'h0, 3'(8 - i)}),
                r);
        end
    endtask
    task automatic t_hold;  // full stack holds the acknowledge back
        do_reset;
        for (int i = 0; i < 8; i++) run(pc_stack_pkg::CMD_CALL, 13'h0200);
        irq_req <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge clock);
            if (irq_ack === 1'b1) n++;
        end
        chk("ack while full", 32'h0000_0000, 32'(n));
        run(pc_stack_pkg::CMD_RET, 13'h0000);
        n = 0;
        while (irq_ack !== 1'b1) begin
            @(posedge clock);
            n++;
            if (n > 40) hang;
        end
        irq_req <= 1'b0;
        chk("ack after ret", 32'h0000_0001, 32'(irq_ack));
    endtask
    task automatic t_jump;  // bank, jump, readback, low byte, skip
        apb(1'b1, pc_stack_pkg::OFS_BANK, 32'h0000_0001);
        run(pc_stack_pkg::CMD_JUMP, 13'h1234);
        chk("jump addr", 32'h0000_3234,
            32'(fetch_addr));
        chk("strobe and phase", 32'h0000_0004,
            32'({fetch_strobe, phase}));
        wt(1'b0);
        apb(1'b0, pc_stack_pkg::OFS_RB_LOW, 32'h0000_0000);
        apb(1'b0, pc_stack_pkg::OFS_RB_HIGH, 32'h0000_0000);
        chk("readback high", 32'h0000_0032, r);
        apb(1'b1, pc_stack_pkg::OFS_PC_LOW, 32'h0000_0055);
        wt(1'b1);
        chk("page jump", 32'h0000_3255, 32'(fetch_addr));
        run(pc_stack_pkg::CMD_SKIP_Z, 13'h0000);
        chk("sub result", 32'h0000_0000, 32'(alu_result));
        chk("z and c", 32'h0000_0003,
            32'({alu_flags.z, alu_flags.c}));
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, 32'(err));
    endtask
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, irq_req} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        do_reset;
        t_calls;
        t_rets;
        t_hold;
        t_jump;
        tally_and_finish;
    end
endmodule // test_pc_stack_sequencer
